// ---- design/i2c_bus_monitor.sv ----
/*
 * Synchronises the SCL and SDA pins into pclk and flags start and stop
 * conditions. Assumes the pins are asynchronous to pclk.
 */
`timescale 1ns/100ps

module i2c_bus_monitor
  import i2c_master_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins
  input wire logic scl_i,
  input wire logic sda_i,
  // filtered bus
  output bus_cond_type cond
);

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    bus_cond_type cond;
  } mon_state_type;

  mon_state_type s_q;
  mon_state_type s_d;

  // ****************************************
  // synchroniser and condition detector
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.scl_sync = {s_q.scl_sync[1:0], scl_i};
    s_d.sda_sync = {s_q.sda_sync[1:0], sda_i};
    s_d.cond.start = 1'b0;
    s_d.cond.stop = 1'b0;
    // a change counts once stages two and three agree
    if (s_q.scl_sync[1] == s_q.scl_sync[2])
    begin
      s_d.cond.scl = s_q.scl_sync[2];
    end
    if (s_q.sda_sync[1] == s_q.sda_sync[2])
    begin
      s_d.cond.sda = s_q.sda_sync[2];
      // sda edge while scl high
      if (s_q.cond.scl && s_d.cond.scl && s_q.cond.sda && !s_d.cond.sda)
      begin
        s_d.cond.start = 1'b1;
      end
      if (s_q.cond.scl && s_d.cond.scl && !s_q.cond.sda && s_d.cond.sda)
      begin
        s_d.cond.stop = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '{scl_sync: 3'h7, sda_sync: 3'h7, cond: '{scl: 1'b1, sda: 1'b1, default: 1'b0}};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cond = s_q.cond;

endmodule : i2c_bus_monitor

// ---- design/i2c_master_pkg.sv ----
/*
 * Shared constants and types for the I2C master status and data block.
 * Assumes a 100 MHz APB clock and a 32-bit APB address and data bus.
 */
package i2c_master_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCL_QUARTER_NS = 2500;
  // least time per quarter bit, rounded up
  localparam int unsigned QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [31:0] ADDR_CTRL = 32'hffff_0900;
  localparam logic [31:0] ADDR_STATUS = 32'hffff_0904;
  localparam logic [31:0] ADDR_RX = 32'hffff_0908;
  localparam logic [31:0] ADDR_TX = 32'hffff_090c;
  localparam logic [31:0] ADDR_XFER = 32'hffff_0930;
  localparam logic [31:0] ADDR_IRQ_ST = 32'hffff_0940;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'hffff_0944;

  // ****************************************
  // status fields
  // ****************************************
  localparam int ST_BUS_BUSY = 10;
  localparam int ST_RX_OVF = 9;
  localparam int ST_DONE = 8;
  localparam int ST_NACK_DATA = 7;
  localparam int ST_ACTIVE = 6;
  localparam int ST_ARB = 5;
  localparam int ST_NACK_ADDR = 4;
  localparam int ST_RXQ = 3;
  localparam int ST_TXQ = 2;
  localparam int ST_TXLVL_LSB = 0;
  localparam logic [1:0] TXLVL_EMPTY = 2'h0;
  localparam logic [1:0] TXLVL_ONE = 2'h1;
  localparam logic [1:0] TXLVL_FULL = 2'h3;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // ****************************************
  // control fields
  // ****************************************
  localparam int CTRL_W = 9;
  localparam int CTRL_EN = 0;
  localparam int CTRL_RX_IE = 4;
  localparam int CTRL_TX_IE = 5;
  localparam int CTRL_ARB_IE = 6;
  localparam int CTRL_NACK_IE = 7;
  localparam int CTRL_DONE_IE = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

  // ****************************************
  // transfer register fields
  // ****************************************
  localparam int XF_ADDR_LSB = 0;
  localparam int XF_CNT_LSB = 8;
  localparam int XF_GO = 31;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] RX_IDLE_BYTE = 8'hff;
  localparam logic [3:0] BITS_PER_SLOT = 4'h8;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ENG_IDLE, ENG_START, ENG_BITS, ENG_STOP} eng_state_type;

  typedef struct packed {
    logic scl;
    logic sda;
    logic start;
    logic stop;
  } bus_cond_type;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } pad_drive_type;

endpackage : i2c_master_pkg

// ---- design/i2c_master_status_and_data.sv ----
/*
 * I2C master with its status, receive and transmit data registers, an APB
 * slave, sticky interrupt flags and a small byte engine.
 * Assumes open-drain SCL/SDA resolved outside; pins are asynchronous.
 */
`timescale 1ns/100ps

module i2c_master_status_and_data
  import i2c_master_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output pad_drive_type pad,
  // interrupt
  output logic irq
);

  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] FIFO_FULL = CW'(FIFO_DEPTH);
  localparam logic [CW-1:0] ONE_BYTE = CW'(1);
  localparam logic [15:0] QC_LAST = 16'(QUARTER_CYC - 1);

  typedef struct packed {
    eng_state_type st;
    logic [15:0] tick;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] left;
    logic addr_ph;
    logic rd;
    logic stopreq;
    logic scl_oe;
    logic sda_oe;
    logic go;
    logic [7:0] xaddr;
    logic [7:0] xcnt;
    logic bus_busy;
    logic ovf;
    logic done;
    logic nack_d;
    logic nack_a;
    logic arb;
    logic addr_w;
    logic [CTRL_W-1:0] ctrl;
    logic [7:0] tx_hold;
    logic [FIFO_DEPTH-1:0][7:0] txm;
    logic [CW-1:0] txc;
    logic [FIFO_DEPTH-1:0][7:0] rxm;
    logic [CW-1:0] rxc;
    logic [15:0] irq_st;
    logic [15:0] irq_mask;
    logic [31:0] prdata;
    logic pslverr;
  } state_type;

  state_type s_q;
  state_type s_d;
  bus_cond_type cond;

  logic setup;
  logic access;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic [7:0] rx_byte;
  logic tick_end;
  logic stall;
  logic receiving;
  logic drive_bit;
  logic [15:0] irq_clr;
  logic [15:0] rise;
  logic [15:0] irq_gate;

  // ****************************************
  // pin synchroniser
  // ****************************************
  i2c_bus_monitor u_mon (
    .pclk(pclk),
    .presetn(presetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .cond(cond)
  );

  // ****************************************
  // status word
  // ****************************************
  function automatic logic [15:0] status_of(input state_type x);
    logic [15:0] r;
    logic [1:0] lvl;
    r = STATUS_RESET;
    // level code
    // transmit fifo level
    if (x.txc == '0)
      lvl = TXLVL_EMPTY;
    else if (x.txc == FIFO_FULL)
      lvl = TXLVL_FULL;
    else
      lvl = TXLVL_ONE;
    r[ST_TXLVL_LSB +: 2] = lvl;
    r[ST_BUS_BUSY] = x.bus_busy;
    r[ST_RX_OVF] = x.ovf;
    r[ST_DONE] = x.done;
    r[ST_NACK_DATA] = x.nack_d;
    r[ST_ACTIVE] = (x.st != ENG_IDLE);
    r[ST_ARB] = x.arb;
    r[ST_NACK_ADDR] = x.nack_a;
    r[ST_RXQ] = (x.rxc != '0);
    r[ST_TXQ] = x.addr_w && (x.txc <= ONE_BYTE);
    return r;
  endfunction : status_of

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    setup = psel && !penable;
    access = psel && penable;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_byte = DATA_RESET;
    irq_clr = 16'h0000;
    receiving = s_q.rd && !s_q.addr_ph;
    drive_bit = 1'b1;
    if (s_q.bitn != 4'h0)
      drive_bit = receiving ? 1'b1 : s_q.sh[7];
    else if (receiving)
      drive_bit = (s_q.left == 8'h00);
    tick_end = (s_q.tick == QC_LAST);
    stall = (s_q.st == ENG_BITS) && (s_q.q == 2'h2) && !cond.scl;

    // bus activity
    // start sets busy
    if (cond.start)
      s_d.bus_busy = 1'b1;
    else if (cond.stop)
      s_d.bus_busy = 1'b0;

    // apb setup: capture read data and error
    if (setup)
    begin
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
      case (paddr)
        ADDR_CTRL: s_d.prdata[CTRL_W-1:0] = s_q.ctrl;
        ADDR_STATUS: s_d.prdata[15:0] = status_of(s_q);
        ADDR_RX: s_d.prdata[7:0] = (s_q.rxc != '0) ? s_q.rxm[0] : DATA_RESET;
        ADDR_TX: s_d.prdata = 32'h0000_0000;
        ADDR_XFER: s_d.prdata = {s_q.go, 15'h0000, s_q.xcnt, s_q.xaddr};
        ADDR_IRQ_ST: s_d.prdata[15:0] = s_q.irq_st;
        ADDR_IRQ_MASK: s_d.prdata[15:0] = s_q.irq_mask;
        default: s_d.pslverr = 1'b1;
      endcase
    end

    // apb access: side effects
    if (access && !s_q.pslverr)
    begin
      if (pwrite)
      begin
        case (paddr)
          ADDR_CTRL: s_d.ctrl = pwdata[CTRL_W-1:0];
          ADDR_TX:
          begin
            tx_push = 1'b1;
            s_d.tx_hold = pwdata[7:0];
          end
          ADDR_XFER:
          begin
            s_d.xaddr = pwdata[XF_ADDR_LSB +: 8];
            s_d.xcnt = pwdata[XF_CNT_LSB +: 8];
            s_d.go = pwdata[XF_GO];
          end
          ADDR_IRQ_ST: irq_clr = pwdata[15:0];
          ADDR_IRQ_MASK: s_d.irq_mask = pwdata[15:0];
          default: s_d.irq_mask = s_q.irq_mask;
        endcase
      end
      else if (paddr == ADDR_RX && s_q.rxc != '0)
      begin
        rx_pop = 1'b1;
      end
    end

    // byte engine
    if (s_q.st == ENG_IDLE)
    begin
      s_d.tick = 16'h0000;
      s_d.q = 2'h0;
      s_d.scl_oe = 1'b0;
      s_d.sda_oe = 1'b0;
      // back off while another master holds the bus
      if (s_q.go && s_q.ctrl[CTRL_EN] && !s_q.bus_busy)
      begin
        s_d.st = ENG_START;
        s_d.go = 1'b0;
        s_d.done = 1'b0;
        s_d.nack_a = 1'b0;
        s_d.nack_d = 1'b0;
        s_d.arb = 1'b0;
        s_d.stopreq = 1'b0;
      end
    end
    else if (!stall)
    begin
      s_d.tick = tick_end ? 16'h0000 : s_q.tick + 16'h0001;
      if (tick_end)
      begin
        s_d.q = s_q.q + 2'h1;
        case (s_q.st)
          ENG_START:
          begin
            if (s_q.q == 2'h0)
              s_d.sda_oe = 1'b1;
            if (s_q.q == 2'h1)
              s_d.scl_oe = 1'b1;
            if (s_q.q == 2'h3)
            begin
              s_d.st = ENG_BITS;
              s_d.bitn = BITS_PER_SLOT;
              s_d.sh = s_q.xaddr;
              s_d.addr_ph = 1'b1;
              s_d.rd = s_q.xaddr[0];
            end
          end
          ENG_BITS:
          begin
            case (s_q.q)
              2'h0: s_d.sda_oe = !drive_bit;
              2'h1: s_d.scl_oe = 1'b0;
              2'h2:
              begin
                if (s_q.bitn != 4'h0 && !receiving && drive_bit && !cond.sda)
                begin
                  s_d.arb = 1'b1;
                  s_d.st = ENG_IDLE;
                  s_d.addr_w = 1'b0;
                  s_d.scl_oe = 1'b0;
                  s_d.sda_oe = 1'b0;
                end
                else if (s_q.bitn != 4'h0)
                  s_d.sh = {s_q.sh[6:0], cond.sda};
                else if (!receiving && cond.sda)
                begin
                  s_d.stopreq = 1'b1;
                  if (s_q.addr_ph)
                    s_d.nack_a = 1'b1;
                  else
                    s_d.nack_d = 1'b1;
                end
              end
              default:
              begin
                s_d.scl_oe = 1'b1;
                if (s_q.bitn != 4'h0)
                  s_d.bitn = s_q.bitn - 4'h1;
                else if (s_q.stopreq)
                  s_d.st = ENG_STOP;
                else if (s_q.addr_ph && s_q.rd)
                begin
                  s_d.addr_ph = 1'b0;
                  s_d.bitn = BITS_PER_SLOT;
                  s_d.sh = RX_IDLE_BYTE;
                  s_d.left = s_q.xcnt;
                end
                else if (receiving)
                begin
                  rx_push = 1'b1;
                  rx_byte = s_q.sh;
                  s_d.sh = RX_IDLE_BYTE;
                  if (s_q.left == 8'h00)
                    s_d.st = ENG_STOP;
                  else
                  begin
                    s_d.left = s_q.left - 8'h01;
                    s_d.bitn = BITS_PER_SLOT;
                  end
                end
                else
                begin
                  // address + write sent, feed next byte
                  s_d.addr_w = 1'b1;
                  s_d.addr_ph = 1'b0;
                  if (s_q.txc != '0)
                  begin
                    tx_pop = 1'b1;
                    s_d.sh = s_q.txm[0];
                    s_d.bitn = BITS_PER_SLOT;
                  end
                  else
                    s_d.st = ENG_STOP;
                end
              end
            endcase
          end
          ENG_STOP:
          begin
            case (s_q.q)
              2'h0: s_d.sda_oe = 1'b1;
              2'h1: s_d.scl_oe = 1'b0;
              2'h2: s_d.sda_oe = 1'b0;
              default:
              begin
                s_d.st = ENG_IDLE;
                s_d.done = 1'b1;
                s_d.addr_w = 1'b0;
              end
            endcase
          end
          default: s_d.st = ENG_IDLE;
        endcase
      end
    end

    // transmit fifo, head at index 0
    if (tx_pop)
    begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++)
        s_d.txm[i] = s_q.txm[i+1];
      s_d.txc = s_q.txc - ONE_BYTE;
    end
    // writes to a full fifo are dropped
    if (tx_push && (s_d.txc != FIFO_FULL))
    begin
      s_d.txm[s_d.txc] = pwdata[7:0];
      s_d.txc = s_d.txc + ONE_BYTE;
    end

    // receive fifo
    if (rx_pop)
    begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++)
        s_d.rxm[i] = s_q.rxm[i+1];
      s_d.rxc = s_q.rxc - ONE_BYTE;
      s_d.ovf = 1'b0;
    end
    if (rx_push)
    begin
      if (s_d.rxc == FIFO_FULL)
        s_d.ovf = 1'b1;
      else
      begin
        s_d.rxm[s_d.rxc] = rx_byte;
        s_d.rxc = s_d.rxc + ONE_BYTE;
      end
    end

    // sticky interrupt flags, set wins over clear
    // enables gate event sources, except overflow which is always passed
    irq_gate = 16'h0000;
    irq_gate[ST_RX_OVF] = 1'b1;
    irq_gate[ST_DONE] = s_q.ctrl[CTRL_DONE_IE];
    irq_gate[ST_NACK_DATA] = s_q.ctrl[CTRL_NACK_IE];
    irq_gate[ST_NACK_ADDR] = s_q.ctrl[CTRL_NACK_IE];
    irq_gate[ST_ARB] = s_q.ctrl[CTRL_ARB_IE];
    irq_gate[ST_TXQ] = s_q.ctrl[CTRL_TX_IE];
    irq_gate[ST_RXQ] = s_q.ctrl[CTRL_RX_IE];
    rise = status_of(s_d) & ~status_of(s_q) & irq_gate;
    s_d.irq_st = (s_q.irq_st & ~irq_clr) | rise;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pready = psel && penable;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr && psel && penable;
  assign pad = '{scl_o: 1'b0, scl_oe: s_q.scl_oe, sda_o: 1'b0, sda_oe: s_q.sda_oe};
  assign irq = |(s_q.irq_st & s_q.irq_mask);

endmodule : i2c_master_status_and_data

// ---- testbench/i2c_master_chk.sv ----
/*
 * Port checker for the i2c master block, bound into its top module.
 * Assumes the bus is idle (both lines high) when reset is released.
 */
`timescale 1ns/100ps

module i2c_master_chk
  import i2c_master_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // pins and interrupt
  input wire logic scl_i,
  input wire logic sda_i,
  input wire pad_drive_type pad,
  input wire logic irq
);
  logic [1:0] scl_q;
  logic [1:0] sda_q;
  logic busy_q;
  logic [3:0] age_q;
  logic rd;
  logic st;

  assign rd = psel && penable && !pwrite;
  assign st = rd && paddr == ADDR_STATUS;

  // ********
  // start and stop seen on the pins
  // ********
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      busy_q <= 1'b0;
      age_q <= 4'h0;
    end
    else
    begin
      scl_q <= {scl_q[0], scl_i};
      sda_q <= {sda_q[0], sda_i};
      if (scl_q == 2'h3 && sda_q[1] != sda_q[0])
      begin
        busy_q <= sda_q[1];
        age_q <= 4'h0;
      end
      else if (age_q != 4'hf)
        age_q <= age_q + 4'h1;
    end
  end

  // ********
  // assertions
  // ********
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  busy_set_a:
    assert property (st && age_q > 4'h8 && busy_q |-> prdata[ST_BUS_BUSY])
    else $error("bus busy flag missing after start");
  busy_clear_a:
    assert property (st && age_q > 4'h8 && !busy_q |-> !prdata[ST_BUS_BUSY])
    else $error("bus busy flag left after stop");
  ovf_rx_a:
    assert property (st && prdata[ST_RX_OVF] |-> prdata[ST_RXQ])
    else $error("overflow shown with empty receive fifo");
  done_free_a:
    assert property (st && prdata[ST_DONE] |-> !prdata[ST_BUS_BUSY])
    else $error("transfer done while bus busy");
  active_drive_a:
    assert property (st && $past(pad.scl_oe) |-> prdata[ST_ACTIVE])
    else $error("master drives clock but not active");
  txq_level_a:
    assert property (st && prdata[ST_TXQ] |-> prdata[1:0] != TXLVL_FULL)
    else $error("transmit request with full fifo");
  level_code_a:
    assert property (st |-> prdata[1:0] != 2'h2 && prdata[31:11] == 21'h0)
    else $error("bad status level code or upper bits");
  rx_width_a:
    assert property (rd && paddr == ADDR_RX |-> prdata[31:8] == 24'h0)
    else $error("receive data wider than a byte");
  tx_zero_a:
    assert property (rd && paddr == ADDR_TX |-> prdata == 32'h0)
    else $error("transmit data register readable");
  mask_gate_a:
    assert property (psel && penable && pwrite && paddr == ADDR_IRQ_MASK && pwdata == 32'h0
      |-> ##2 !irq)
    else $error("interrupt high with all sources masked");
endmodule : i2c_master_chk

bind i2c_master_status_and_data i2c_master_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_i2c_master_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .scl_i(scl_i), .sda_i(sda_i),
  .pad(pad), .irq(irq));

// ---- testbench/i2c_slave_model.sv ----
/*
 * Behavioural i2c slave: acks its own address, takes or returns bytes,
 * stretches the clock after the address slot and each written byte's slot. Assumes pulled-up lines.
 */
`timescale 1ns/100ps

module i2c_slave_model
#(
  parameter logic [6:0] ADDR7 = 7'h2a,
  parameter logic [7:0] ACK_LIMIT = 8'h1,
  parameter logic [7:0] RD_FIRST = 8'ha0,
  parameter int STRETCH_NS = 3000
)
(
  // bus
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull,
  // observation
  output logic [7:0] last_rx,
  output logic [7:0] rx_cnt
);
  logic [7:0] sr;
  logic [7:0] d;
  logic rd;
  logic ack;

  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    last_rx = 8'h0;
    rx_cnt = 8'h0;
  end

  task automatic take(output logic [7:0] b);
    repeat (8)
    begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
  endtask : take

  // ack slot, then next bit set before the clock is let go
  task automatic slot(input logic low, input logic nxt);
    @(negedge scl);
    sda_pull = low;
    @(negedge scl);
    sda_pull = nxt;
    scl_pull = 1'b1;
    #(STRETCH_NS);
    scl_pull = 1'b0;
  endtask : slot

  always @(negedge sda)
  begin
    if (scl === 1'b1)
    begin
      disable fork;
      sda_pull = 1'b0;
      scl_pull = 1'b0;
      fork
        begin
          take(sr);
          rd = sr[0];
          d = RD_FIRST;
          ack = sr[7:1] == ADDR7;
          slot(ack, ack && rd && !d[7]);
          while (ack)
          begin
            if (rd)
            begin
              for (int i = 6; i >= 0; i--)
              begin
                @(negedge scl);
                sda_pull = !d[i];
              end
              @(negedge scl);
              sda_pull = 1'b0;
              @(posedge scl);
              ack = !sda;
              d = d + 8'h1;
              @(negedge scl);
              sda_pull = ack && !d[7];
            end
            else
            begin
              take(last_rx);
              ack = rx_cnt < ACK_LIMIT;
              rx_cnt = rx_cnt + 8'h1;
              slot(ack, 1'b0);
            end
          end
        end
      join_none
    end
  end
endmodule : i2c_slave_model

// ---- testbench/tb.sv ----
/*
 * Self-checking bench for the i2c master block: apb master, slave model.
 * Assumes open-drain lines with pull-ups, resolved here.
 */
`timescale 1ns/100ps

module tb
  import i2c_master_pkg::*;
;
  typedef struct packed {
    logic wr;
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] x;
    logic err;
  } row_type;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  row_type rows [0:17] = '{
    '{1'b0, ADDR_STATUS, 32'h0, ALL, 32'h0, 1'b0}, '{1'b0, ADDR_RX, 32'h0, ALL, 32'h0, 1'b0},
    '{1'b0, ADDR_TX, 32'h0, ALL, 32'h0, 1'b0}, '{1'b1, ADDR_STATUS, ALL, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_STATUS, 32'h0, ALL, 32'h0, 1'b0}, '{1'b1, ADDR_RX, ALL, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_RX, 32'h0, ALL, 32'h0, 1'b0}, '{1'b0, 32'hffff_0910, 32'h0, 32'h0, 32'h0, 1'b1},
    '{1'b1, 32'hffff_0948, 32'h0, 32'h0, 32'h0, 1'b1},
    '{1'b1, ADDR_CTRL, 32'h1f1, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_CTRL, 32'h0, ALL, 32'h1f1, 1'b0},
    '{1'b1, ADDR_IRQ_MASK, 32'h7ff, 32'h0, 32'h0, 1'b0},
    '{1'b1, ADDR_TX, 32'h11, 32'h0, 32'h0, 1'b0}, '{1'b0, ADDR_STATUS, 32'h0, 32'h3, 32'h1, 1'b0},
    '{1'b1, ADDR_TX, 32'h22, 32'h0, 32'h0, 1'b0}, '{1'b0, ADDR_STATUS, 32'h0, 32'h3, 32'h3, 1'b0},
    '{1'b1, ADDR_TX, 32'h33, 32'h0, 32'h0, 1'b0}, '{1'b0, ADDR_STATUS, 32'h0, 32'h3, 32'h3, 1'b0}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  pad_drive_type pad;
  logic scl;
  logic sda;
  logic m_scl;
  logic m_sda;
  logic other_pull = 1'b0;
  logic [7:0] last_rx;
  logic [7:0] rx_cnt;
  logic [31:0] rdata;
  logic rerr;
  int errors = 0;
  int compares = 0;

  always #5 pclk = ~pclk;
  assign scl = !(pad.scl_oe || m_scl);
  assign sda = !(pad.sda_oe || m_sda || other_pull);

  i2c_master_status_and_data #(.FIFO_DEPTH(2)) i_i2c_master_status_and_data (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .sda_i(sda), .pad(pad), .irq(irq));
  i2c_slave_model i_i2c_slave_model (.scl(scl), .sda(sda), .scl_pull(m_scl),
    .sda_pull(m_sda), .last_rx(last_rx), .rx_cnt(rx_cnt));

  task automatic test_done();
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] x, input logic [31:0] got);
    compares++;
    if (got !== x)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, x, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic st(input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status", x, rdata & m);
  endtask : st

  task automatic wait_st(input int b, input logic v);
    int k;
    k = 0;
    do
    begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end
    while (rdata[b] !== v && k < 20000);
    check("status bit", {31'h0, v}, {31'h0, rdata[b]});
  endtask : wait_st

  task automatic irq_chk(input logic [31:0] x);
    apb(1'b0, ADDR_IRQ_ST, 32'h0);
    check("irq status", x, rdata);
    check("irq line", 32'h1, {31'h0, irq});
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    apb(1'b0, ADDR_IRQ_MASK, 32'h0);
    check("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, ADDR_IRQ_MASK, 32'h7ff);
    apb(1'b1, ADDR_IRQ_ST, 32'hffff);
    apb(1'b0, ADDR_IRQ_ST, 32'h0);
    check("irq cleared", 32'h0, rdata | {31'h0, irq});
  endtask : irq_chk

  initial
  begin
    #1_000_000;
    errors++;
    test_done();
  end

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      check("row data", rows[i].x, rdata & rows[i].m);
      check("row error", {31'h0, rows[i].err}, {31'h0, rerr});
    end
    // write of two bytes, second refused by the slave
    apb(1'b1, ADDR_XFER, 32'h8000_0054);
    wait_st(ST_ACTIVE, 1'b1);
    wait_st(ST_BUS_BUSY, 1'b1);
    wait_st(ST_TXQ, 1'b1);
    wait_st(ST_DONE, 1'b1);
    st(32'h7ff, 32'h180);
    check("bytes sent", 32'h222, {16'h0, rx_cnt, last_rx});
    irq_chk(32'h184);
    // address refused, only the done source enabled
    apb(1'b1, ADDR_CTRL, 32'h101);
    apb(1'b1, ADDR_XFER, 32'h8000_0032);
    wait_st(ST_ACTIVE, 1'b1);
    wait_st(ST_DONE, 1'b1);
    st(32'h0b0, 32'h010);
    irq_chk(32'h100);
    // fifo left unread to force an overflow
    apb(1'b1, ADDR_CTRL, 32'h011);
    apb(1'b1, ADDR_XFER, 32'h8000_0255);
    wait_st(ST_ACTIVE, 1'b1);
    wait_st(ST_DONE, 1'b1);
    st(32'h208, 32'h208);
    apb(1'b0, ADDR_RX, 32'h0);
    check("rx byte", 32'ha0, rdata);
    st(32'h200, 32'h0);
    apb(1'b0, ADDR_RX, 32'h0);
    check("rx byte", 32'ha1, rdata);
    st(32'h8, 32'h0);
    irq_chk(32'h208);
    // another master holds data low during the address
    apb(1'b1, ADDR_CTRL, 32'h041);
    apb(1'b1, ADDR_XFER, 32'h8000_00aa);
    wait_st(ST_BUS_BUSY, 1'b1);
    other_pull <= 1'b1;
    wait_st(ST_ARB, 1'b1);
    st(32'h40, 32'h0);
    other_pull <= 1'b0;
    wait_st(ST_BUS_BUSY, 1'b0);
    irq_chk(32'h020);
    // reset in mid-run with a byte queued
    apb(1'b1, ADDR_TX, 32'h5a);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl after reset", 32'h0, rdata);
    st(32'hffff, 32'h0);
    test_done();
  end
endmodule : tb
